// *** hw/byte_fifo.sv ***
// Purpose: Synchronous FIFO with show-ahead output and occupancy count.
// Assumes: DEPTH is a power of two so the pointers wrap on their own.
// Notes: A push while full or a pop while empty is ignored.
module byte_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  fifo_if.store f
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  logic do_push;
  logic do_pop;

  assign do_push = f.push && (cnt_q != FULL_CNT);
  assign do_pop = f.pop && (cnt_q != '0);

  always_ff @(posedge aclk) begin
    if (do_push) begin
      mem_q[wr_q] <= f.wdata;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || f.clear) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (do_pop) begin
        rd_q <= rd_q + 1'b1;
      end
      unique case ({do_push, do_pop})
        2'b10: cnt_q <= cnt_q + 1'b1;
        2'b01: cnt_q <= cnt_q - 1'b1;
        2'b00, 2'b11: cnt_q <= cnt_q;
      endcase
    end
  end

  assign f.rdata = mem_q[rd_q];
  assign f.count = cnt_q;
  assign f.full = (cnt_q == FULL_CNT);
  assign f.empty = (cnt_q == '0);
endmodule

// *** hw/uart_autoflow_control.sv ***
// Purpose: Serial transceiver with automatic RTS and CTS flow control.
// Assumes: 8 data bits, no parity, one stop bit, lines idle high.
// Notes: Registers sit behind an AXI4-Lite slave; only byte lane 0 is used.

// Summary of operation
// (RL1) Autoflow works only with FIFOs enabled.
// (RL2) Both FIFOs hold 16; receive adds 3 error bits.
// (RL3) Receive trigger selects 1, 4, 8 or 14 bytes.
// (RL4) Autoflow enable plus RTS bit gives full autoflow.
// (RL5) Autoflow enable without RTS bit: CTS gating only.
// (RL6) Auto-CTS: start a byte only while CTS active.
// (RL7) Sample CTS before starting each next byte.
// (RL8) Remote drops CTS before last stop bit middle.
// (RL9) CTS loss mid-byte: finish byte, hold the next.
// (RL10) CTS active again: resume pending FIFO bytes.
// (RL11) Auto-CTS mode: CTS changes raise no event.
// (RL12) Without auto-CTS, send regardless of CTS.
// (RL13) Triggers 1/4/8: drop RTS at trigger level.
// (RL14) Triggers 1/4/8: still accept one late byte.
// (RL15) Triggers 1/4/8: restore RTS only when emptied.
// (RL16) Trigger 14: drop RTS at sixteenth byte start.
// (RL17) Trigger 14: restore RTS when space allows.
// (RL18) Trigger 14, FIFO full: first read restores RTS.
// (RL19) Status: CTS in bit 4, change flag bit 0.
// (RL20) CTS passes a two-stage synchroniser first.
module uart_autoflow_control #(
  parameter int BIT_CYCLES = uart_af_pkg::BIT_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [uart_af_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [uart_af_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic serial_input_line,
  output logic serial_output_line,
  input wire logic cts_n,
  output logic rts_n,
  output logic modem_change
);
  import uart_af_pkg::*;

  localparam int CNT_W = $clog2(BIT_CYCLES);
  localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(BIT_CYCLES - 1);
  localparam logic [CNT_W-1:0] BIT_HALF = CNT_W'(BIT_CYCLES / 2);
  localparam logic [4:0] DEPTH_CNT = 5'(FIFO_DEPTH);
  localparam logic [4:0] DEPTH_M1 = 5'(FIFO_DEPTH - 1);

  fifo_if #(.W(RX_W), .DEPTH(FIFO_DEPTH)) rxf ();
  fifo_if #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) txf ();

  byte_fifo #(.W(RX_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo ( // RL2
    .aclk(aclk),
    .aresetn(aresetn),
    .f(rxf.store)
  );
  byte_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo ( // RL2
    .aclk(aclk),
    .aresetn(aresetn),
    .f(txf.store)
  );

  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [7:0] w_byte_q;
  logic w_en_q, have_aw_q, have_w_q;
  logic fifo_en_q, rts_bit_q, autoflow_q, overrun_q, dcts_q;
  logic [1:0] trig_code_q;
  logic cts_s1_q, cts_s2_q, cts_s3_q, modem_change_q;
  logic hold_q, hold_d, rts_n_q;
  tx_state_t tx_st_q;
  rx_state_t rx_st_q;
  logic [CNT_W-1:0] tx_cnt_q, rx_cnt_q;
  logic [2:0] tx_bit_q, rx_bit_q;
  logic [7:0] tx_sh_q, rx_sh_q;
  logic tx_q;

  logic wr_fire, wr_map, rd_fire, rd_map, wr_data, wr_fcr, rd_data, rd_msr;
  logic [7:0] rd_byte;
  logic auto_cts_w, auto_rts_w, big_trig_w, cts_ok_w, rx_cap_full;
  logic [4:0] trig_lvl_w;
  logic tx_go, tx_end, rx_half, rx_end, rx_first_bit, stop_end, rx_busy;
  logic rx_brk, rx_fe;

  // Only the address bits that select a word, 7 down to 2, are decoded.
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] off);
    return a[ADDR_W-1:2] == off[ADDR_W-1:2];
  endfunction

  assign wr_fire = have_aw_q && have_w_q && !bvalid_q;
  assign wr_map = hit(aw_addr_q, ADDR_DATA) || hit(aw_addr_q, ADDR_FCR) ||
                  hit(aw_addr_q, ADDR_MCR) || hit(aw_addr_q, ADDR_LSR) ||
                  hit(aw_addr_q, ADDR_MSR);
  assign wr_data = wr_fire && w_en_q && hit(aw_addr_q, ADDR_DATA);
  assign wr_fcr = wr_fire && w_en_q && hit(aw_addr_q, ADDR_FCR);
  assign rd_fire = arvalid && arready_q;
  assign rd_map = hit(araddr, ADDR_DATA) || hit(araddr, ADDR_FCR) ||
                  hit(araddr, ADDR_MCR) || hit(araddr, ADDR_LSR) ||
                  hit(araddr, ADDR_MSR);
  assign rd_data = rd_fire && hit(araddr, ADDR_DATA);
  assign rd_msr = rd_fire && hit(araddr, ADDR_MSR);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      have_aw_q <= 1'b0;
      have_w_q <= 1'b0;
      aw_addr_q <= '0;
      w_byte_q <= 8'h00;
      w_en_q <= 1'b0;
    end else begin
      if (awvalid && awready_q) begin
        aw_addr_q <= awaddr;
        have_aw_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (wvalid && wready_q) begin
        w_byte_q <= wdata[7:0];
        w_en_q <= wstrb[0];
        have_w_q <= 1'b1;
        wready_q <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_map ? RESP_OKAY : RESP_SLVERR;
        have_aw_q <= 1'b0;
        have_w_q <= 1'b0;
      end
      if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    if (hit(araddr, ADDR_DATA)) begin
      rd_byte = rxf.rdata[7:0];
    end else if (hit(araddr, ADDR_FCR)) begin
      rd_byte = {trig_code_q, 5'h00, fifo_en_q};
    end else if (hit(araddr, ADDR_MCR)) begin
      rd_byte = {2'h0, autoflow_q, 3'h0, rts_bit_q, 1'b0};
    end else if (hit(araddr, ADDR_LSR)) begin
      rd_byte[LSR_DR] = !rxf.empty;
      rd_byte[LSR_OE] = overrun_q;
      rd_byte[LSR_PE] = !rxf.empty && rxf.rdata[8];
      rd_byte[LSR_FE] = !rxf.empty && rxf.rdata[9];
      rd_byte[LSR_BI] = !rxf.empty && rxf.rdata[10];
      rd_byte[LSR_THRE] = txf.empty;
      rd_byte[LSR_TEMT] = txf.empty && tx_st_q == TX_IDLE;
    end else if (hit(araddr, ADDR_MSR)) begin
      rd_byte[MSR_CTS] = cts_ok_w; // RL19
      rd_byte[MSR_DCTS] = dcts_q; // RL19
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (rd_fire) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= {24'h00_0000, rd_byte};
      rresp_q <= rd_map ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fifo_en_q <= FCR_RST[FCR_FIFO_EN];
      trig_code_q <= FCR_RST[FCR_TRIG_LSB +: 2];
      rts_bit_q <= MCR_RST[MCR_RTS];
      autoflow_q <= MCR_RST[MCR_AUTOFLOW];
    end else if (wr_fire && w_en_q) begin
      if (hit(aw_addr_q, ADDR_FCR)) begin
        fifo_en_q <= w_byte_q[FCR_FIFO_EN];
        trig_code_q <= w_byte_q[FCR_TRIG_LSB +: 2]; // RL3
      end
      if (hit(aw_addr_q, ADDR_MCR)) begin
        rts_bit_q <= w_byte_q[MCR_RTS];
        autoflow_q <= w_byte_q[MCR_AUTOFLOW];
      end
    end
  end

  // Character mode keeps the FIFOs but lets them hold a single byte.
  assign auto_cts_w = fifo_en_q && autoflow_q; // RL1 RL5
  assign auto_rts_w = fifo_en_q && autoflow_q && rts_bit_q; // RL1 RL4
  assign big_trig_w = trig_code_q == TRIG_CODE_14;
  always_comb begin
    unique case (trig_code_q)
      TRIG_CODE_1: trig_lvl_w = TRIG_LVL_1;
      TRIG_CODE_4: trig_lvl_w = TRIG_LVL_4;
      TRIG_CODE_8: trig_lvl_w = TRIG_LVL_8;
      TRIG_CODE_14: trig_lvl_w = TRIG_LVL_14;
    endcase
  end
  assign rx_cap_full = fifo_en_q ? rxf.full : !rxf.empty;

  // A mode switch flushes both FIFOs so no stale depth survives it.
  assign rxf.clear = wr_fcr &&
                     (w_byte_q[FCR_RX_CLR] || w_byte_q[FCR_FIFO_EN] != fifo_en_q);
  assign txf.clear = wr_fcr &&
                     (w_byte_q[FCR_TX_CLR] || w_byte_q[FCR_FIFO_EN] != fifo_en_q);
  assign txf.push = wr_data && (fifo_en_q ? !txf.full : txf.empty);
  assign txf.wdata = w_byte_q;
  assign rxf.pop = rd_data && !rxf.empty;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cts_s1_q <= 1'b1;
      cts_s2_q <= 1'b1;
      cts_s3_q <= 1'b1;
    end else begin
      cts_s1_q <= cts_n; // RL20
      cts_s2_q <= cts_s1_q; // RL20
      cts_s3_q <= cts_s2_q;
    end
  end
  assign cts_ok_w = !cts_s2_q;

  // A change that coincides with the status read stays flagged.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dcts_q <= 1'b0;
      modem_change_q <= 1'b0;
    end else begin
      if (cts_s2_q != cts_s3_q) begin
        dcts_q <= 1'b1; // RL19
      end else if (rd_msr) begin
        dcts_q <= 1'b0; // RL19
      end
      modem_change_q <= dcts_q && !auto_cts_w; // RL11
    end
  end

  // CTS is only looked at here, so a byte in flight always completes.
  assign tx_go = tx_st_q == TX_IDLE && !txf.empty &&
                 (!auto_cts_w || cts_ok_w); // RL6 RL7 RL10 RL12
  assign tx_end = tx_cnt_q == BIT_LAST;
  assign txf.pop = tx_go;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_st_q <= TX_IDLE;
      tx_cnt_q <= '0;
      tx_bit_q <= 3'h0;
      tx_sh_q <= 8'h00;
      tx_q <= 1'b1;
    end else begin
      tx_cnt_q <= (tx_st_q == TX_IDLE || tx_end) ? '0 : tx_cnt_q + 1'b1;
      unique case (tx_st_q)
        TX_IDLE: if (tx_go) begin
          tx_st_q <= TX_START;
          tx_sh_q <= txf.rdata;
          tx_q <= 1'b0;
        end
        TX_START: if (tx_end) begin
          tx_st_q <= TX_DATA;
          tx_bit_q <= 3'h0;
          tx_q <= tx_sh_q[0];
        end
        TX_DATA: if (tx_end) begin
          tx_sh_q <= {1'b0, tx_sh_q[7:1]};
          tx_bit_q <= tx_bit_q + 1'b1;
          tx_q <= (tx_bit_q == 3'h7) ? 1'b1 : tx_sh_q[1];
          if (tx_bit_q == 3'h7) begin
            tx_st_q <= TX_STOP;
          end
        end
        TX_STOP: if (tx_end) begin
          tx_st_q <= TX_IDLE; // RL9
        end
      endcase
    end
  end

  assign rx_half = rx_cnt_q == BIT_HALF;
  assign rx_end = rx_cnt_q == BIT_LAST;
  assign rx_first_bit = rx_st_q == RX_START && rx_half && !serial_input_line;
  assign stop_end = rx_st_q == RX_STOP && rx_end;
  assign rx_busy = rx_st_q != RX_IDLE;
  assign rx_fe = !serial_input_line;
  assign rx_brk = rx_fe && rx_sh_q == 8'h00;
  assign rxf.push = stop_end && !rx_cap_full; // RL14
  assign rxf.wdata = {rx_brk, rx_fe, 1'b0, rx_sh_q}; // RL2

  // Data and stop bits are sampled mid-bit, a full bit after the start.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_st_q <= RX_IDLE;
      rx_cnt_q <= '0;
      rx_bit_q <= 3'h0;
      rx_sh_q <= 8'h00;
    end else begin
      rx_cnt_q <= (rx_st_q == RX_IDLE || rx_end || rx_first_bit) ?
                  '0 : rx_cnt_q + 1'b1;
      unique case (rx_st_q)
        RX_IDLE: if (!serial_input_line) begin
          rx_st_q <= RX_START;
        end
        RX_START: if (rx_half) begin
          rx_st_q <= serial_input_line ? RX_IDLE : RX_DATA;
          rx_bit_q <= 3'h0;
        end
        RX_DATA: if (rx_end) begin
          rx_sh_q <= {serial_input_line, rx_sh_q[7:1]};
          rx_bit_q <= rx_bit_q + 1'b1;
          if (rx_bit_q == 3'h7) begin
            rx_st_q <= RX_STOP;
          end
        end
        RX_STOP: if (rx_end) begin
          rx_st_q <= RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overrun_q <= 1'b0;
    end else if (stop_end && rx_cap_full) begin
      overrun_q <= 1'b1;
    end else if (rd_fire && hit(araddr, ADDR_LSR)) begin
      overrun_q <= 1'b0;
    end
  end

  always_comb begin
    hold_d = hold_q;
    if (!auto_rts_w) begin
      hold_d = 1'b0;
    end else if (!big_trig_w) begin
      if (rxf.count >= trig_lvl_w) begin
        hold_d = 1'b1; // RL13
      end else if (rxf.count == 5'h00) begin
        hold_d = 1'b0; // RL15
      end
    end else if (rx_first_bit && rxf.count >= DEPTH_M1) begin
      hold_d = 1'b1; // RL16
    end else if ((rxf.count < DEPTH_CNT && !rx_busy) ||
                 rxf.count < DEPTH_M1 || (rxf.full && rxf.pop)) begin
      hold_d = 1'b0; // RL17 RL18
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_q <= 1'b0;
      rts_n_q <= 1'b1;
    end else begin
      hold_q <= hold_d;
      rts_n_q <= !(rts_bit_q && !hold_d); // RL4 RL5
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign serial_output_line = tx_q;
  assign rts_n = rts_n_q;
  assign modem_change = modem_change_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_tx_leave_idle;
    tx_st_q == TX_IDLE ##1 tx_st_q == TX_START;
  endsequence
  sequence s_tx_finish;
    tx_st_q != TX_IDLE ##1 tx_st_q == TX_IDLE;
  endsequence

  AST_CHAR_MODE_RTS: assert property ( // RL1
    !fifo_en_q |=> rts_n_q == !$past(rts_bit_q))
    else $error("RTS followed flow logic in character mode");
  AST_TX_CTS_GATE: assert property ( // RL6
    s_tx_leave_idle |-> $past(!auto_cts_w || cts_ok_w))
    else $error("Byte started while CTS inactive");
  AST_TX_FINISH_BYTE: assert property ( // RL9
    s_tx_finish |-> $past(tx_st_q) == TX_STOP)
    else $error("Byte aborted before its stop bit");
  AST_TX_UNGATED: assert property ( // RL12
    !auto_cts_w && tx_st_q == TX_IDLE && !txf.empty |=> tx_st_q == TX_START)
    else $error("Transmitter idled with data and no CTS gating");
  AST_RTS_AT_TRIGGER: assert property ( // RL13
    auto_rts_w && !big_trig_w && rxf.count >= trig_lvl_w |=> rts_n_q)
    else $error("RTS still active at trigger level");
  AST_RTS_WAIT_EMPTY: assert property ( // RL15
    auto_rts_w && !big_trig_w && hold_q && rxf.count != 5'h00 |=> hold_q)
    else $error("RTS restored before receive FIFO emptied");
  AST_RTS_T14_REARM: assert property ( // RL17
    auto_rts_w && big_trig_w && rxf.count < DEPTH_M1 |=> !rts_n_q)
    else $error("RTS not restored with room at trigger 14");
  AST_NO_CTS_EVENT: assert property ( // RL11
    auto_cts_w |=> !modem_change_q)
    else $error("CTS change raised an event in auto-CTS mode");
  AST_DCTS_CLEAR: assert property ( // RL19
    rd_msr && cts_s2_q == cts_s3_q |=> !dcts_q)
    else $error("CTS change flag survived a status read");
  AST_CTS_SYNC: assert property ( // RL20
    $past(aresetn) && $past(aresetn, 2) |-> cts_s2_q == $past(cts_n, 2))
    else $error("CTS synchroniser depth is not two");
endmodule

// *** shared/fifo_if.sv ***
// Purpose: Carrier between a byte FIFO and the logic that fills and drains it.
// Assumes: Show-ahead read data; pop and push are single-cycle strobes.
// Notes: The store modport belongs to the FIFO itself.
interface fifo_if #(parameter int W = 8, parameter int DEPTH = 16);
  localparam int CW = $clog2(DEPTH + 1);
  logic push;
  logic [W-1:0] wdata;
  logic pop;
  logic clear;
  logic [W-1:0] rdata;
  logic [CW-1:0] count;
  logic full;
  logic empty;
  modport store (input push, wdata, pop, clear,
                 output rdata, count, full, empty);
  modport user (output push, wdata, pop, clear,
                input rdata, count, full, empty);
endinterface

// *** shared/uart_af_pkg.sv ***
// Purpose: Shared constants and types for the autoflow serial transceiver.
// Assumes: AXI4-Lite register slave with 32-bit data, one register a word.
// Notes: Bit timing is counted in aclk cycles at 125 MHz.
package uart_af_pkg;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int RX_ERR_W = 3;
  localparam int RX_W = DATA_W + RX_ERR_W;
  localparam int ADDR_W = 8;

  localparam logic [ADDR_W-1:0] ADDR_DATA = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_FCR = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_MCR = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_LSR = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_MSR = 8'h18;

  localparam int FCR_FIFO_EN = 0;
  localparam int FCR_RX_CLR = 1;
  localparam int FCR_TX_CLR = 2;
  localparam int FCR_TRIG_LSB = 6;
  localparam int MCR_RTS = 1;
  localparam int MCR_AUTOFLOW = 5;
  localparam int LSR_DR = 0;
  localparam int LSR_OE = 1;
  localparam int LSR_PE = 2;
  localparam int LSR_FE = 3;
  localparam int LSR_BI = 4;
  localparam int LSR_THRE = 5;
  localparam int LSR_TEMT = 6;
  localparam int MSR_DCTS = 0;
  localparam int MSR_CTS = 4;

  localparam logic [7:0] FCR_RST = 8'h00;
  localparam logic [7:0] MCR_RST = 8'h00;

  localparam logic [1:0] TRIG_CODE_1 = 2'h0;
  localparam logic [1:0] TRIG_CODE_4 = 2'h1;
  localparam logic [1:0] TRIG_CODE_8 = 2'h2;
  localparam logic [1:0] TRIG_CODE_14 = 2'h3;
  localparam logic [4:0] TRIG_LVL_1 = 5'h01;
  localparam logic [4:0] TRIG_LVL_4 = 5'h04;
  localparam logic [4:0] TRIG_LVL_8 = 5'h08;
  localparam logic [4:0] TRIG_LVL_14 = 5'h0E;

  localparam int CLK_PERIOD_NS = 8;
  localparam int BIT_TIME_NS = 1000;
  localparam int BIT_CYCLES = BIT_TIME_NS / CLK_PERIOD_NS;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
endpackage

// *** sim/remote_serial_model.sv ***
// Purpose: Far-end serial device that sends bytes and drives clear-to-send.
// Assumes: 8N1 framing at BIT_CYCLES clock cycles a bit, lines idle high.
// Notes: The bench decides when to send, so it can test a late byte.
module remote_serial_model #(
  parameter int BIT_CYCLES = 4
) (
  input wire logic aclk,
  input wire logic serial_output_line,
  input wire logic rts_n,
  output logic serial_input_line,
  output logic cts_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got_q[$];

  initial begin
    serial_input_line = 1'b1;
    cts_n = 1'b1;
  end

  // Changes land just after an edge, as a clocked remote would drive them.
  task automatic set_cts(input logic on);
    @(posedge aclk);
    cts_n <= ~on;
  endtask

  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge aclk);
      serial_input_line <= f[i];
      repeat (BIT_CYCLES - 1) @(posedge aclk);
    end
  endtask

  // Samples each bit near its middle, counted from the start edge.
  initial begin : rx_mon
    logic [7:0] b;
    forever begin
      @(negedge serial_output_line);
      repeat (BIT_CYCLES / 2) @(posedge aclk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYCLES) @(posedge aclk);
        b[i] = serial_output_line;
      end
      repeat (BIT_CYCLES) @(posedge aclk);
      got_q.push_back(b);
    end
  end
endmodule

// *** sim/uart_autoflow_control_tb.sv ***
// Purpose: Self-checking bench for automatic RTS and CTS flow control.
// Assumes: Short bit time; registers reached over AXI4-Lite.
// Notes: Only mismatches and the verdict are printed.
module uart_autoflow_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import uart_af_pkg::*;
  localparam int BC = 4;
  localparam int LIMIT = 20000;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic ser_in, ser_out, cts_n, rts_n, modem_change;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;

  uart_autoflow_control #(.BIT_CYCLES(BC)) DUT (.aclk(aclk),
    .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .serial_input_line(ser_in), .serial_output_line(ser_out), .cts_n(cts_n),
    .rts_n(rts_n), .modem_change(modem_change));

  remote_serial_model #(.BIT_CYCLES(BC)) far (.aclk(aclk),
    .serial_output_line(ser_out), .rts_n(rts_n), .serial_input_line(ser_in),
    .cts_n(cts_n));

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic end_sim;
    if (miscompares == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge aclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      end_sim();
    end
  end

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic waitn(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && awready) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", RESP_OKAY, bresp);
    // One idle edge keeps a following call from reassigning bready now.
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] rr);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    v = rdata;
    rr = rresp;
    @(posedge aclk);
  endtask

  task automatic rd_chk(input string n, input logic [7:0] a,
                        input logic [31:0] e);
    rd(a, d, r);
    chk(n, e, d);
  endtask

  task automatic got_chk(input string n, input int cnt, input logic [7:0] e);
    chk(n, cnt, far.got_q.size());
    if (far.got_q.size() > 0) chk(n, e, far.got_q.pop_front());
  endtask

  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hF;
    aresetn = 1'b0;
    waitn(12);
    aresetn <= 1'b1;
    waitn(1);
    chk("rts_n reset", 1, rts_n);
    rd_chk("mcr reset", ADDR_MCR, 32'h00);
    wstrb <= 4'h0;
    wr(ADDR_MCR, 32'h22);
    wstrb <= 4'hF;
    rd_chk("mcr no strobe", ADDR_MCR, 32'h00);
    rd(8'h3C, d, r);
    chk("unmapped resp", RESP_SLVERR, r);
    // Character mode: autoflow bits set but inert, CTS inactive.
    wr(ADDR_MCR, 32'h22);
    wr(ADDR_DATA, 32'h41);
    waitn(12 * BC);
    chk("rts_n char mode", 0, rts_n);
    got_chk("char tx", 1, 8'h41);
    wr(ADDR_FCR, 32'h01);
    wr(ADDR_DATA, 32'h5A);
    waitn(12 * BC);
    chk("rts_n autoflow", 0, rts_n);
    got_chk("held by cts", 0, 8'h00);
    far.set_cts(1'b1);
    waitn(4);
    chk("no cts event", 0, modem_change);
    waitn(12 * BC);
    got_chk("resume", 1, 8'h5A);
    rd_chk("msr changed", ADDR_MSR, 32'h11);
    rd_chk("msr cleared", ADDR_MSR, 32'h10);
    // Drop CTS in mid-byte, well before the stop bit middle.
    wr(ADDR_DATA, 32'h11);
    wr(ADDR_DATA, 32'h22);
    waitn(5 * BC);
    far.set_cts(1'b0);
    waitn(14 * BC);
    got_chk("finish byte", 1, 8'h11);
    far.set_cts(1'b1);
    waitn(12 * BC);
    got_chk("pending byte", 1, 8'h22);
    far.set_cts(1'b0);
    wr(ADDR_MCR, 32'h02);
    wr(ADDR_DATA, 32'h33);
    waitn(12 * BC);
    got_chk("no gating", 1, 8'h33);
    chk("cts event", 1, modem_change);
    rd_chk("msr inactive", ADDR_MSR, 32'h01);
    wr(ADDR_MCR, 32'h20);
    wr(ADDR_DATA, 32'h44);
    waitn(12 * BC);
    chk("rts_n cts only", 1, rts_n);
    got_chk("cts only gate", 0, 8'h00);
    far.set_cts(1'b1);
    waitn(12 * BC);
    got_chk("cts only go", 1, 8'h44);
    wr(ADDR_MCR, 32'h22);
    for (int t = 0; t < 3; t++) begin
      int lvl;
      lvl = (t == 0) ? 1 : (t == 1) ? 4 : 8;
      wr(ADDR_FCR, {24'h0, t[1:0], 6'h01});
      for (int k = 0; k < lvl - 1; k++) far.send_byte(8'(8'h10 * t + k));
      waitn(3);
      chk("rts_n below", 0, rts_n);
      far.send_byte(8'(8'h10 * t + lvl - 1));
      waitn(3);
      chk("rts_n at level", 1, rts_n);
      far.send_byte(8'(8'hE0 + t));
      for (int k = 0; k < lvl; k++)
        rd_chk("rx data", ADDR_DATA, 8'h10 * t + k);
      waitn(3);
      chk("rts_n not empty", 1, rts_n);
      rd_chk("late byte", ADDR_DATA, 8'hE0 + t);
      waitn(3);
      chk("rts_n emptied", 0, rts_n);
    end
    wr(ADDR_FCR, 32'hC1);
    for (int k = 0; k < 15; k++) far.send_byte(8'(8'hA0 + k));
    waitn(3);
    chk("rts_n at 15", 0, rts_n);
    fork
      far.send_byte(8'hAF);
    join_none
    waitn(2 * BC + 3);
    chk("rts_n 16th", 1, rts_n);
    waitn(10 * BC);
    chk("rts_n full", 1, rts_n);
    rd_chk("rx data", ADDR_DATA, 32'hA0);
    waitn(3);
    chk("rts_n first read", 0, rts_n);
    for (int k = 1; k < 16; k++)
      rd_chk("rx data", ADDR_DATA, 8'hA0 + k);
    far.send_byte(8'h5C);
    waitn(3);
    rd_chk("lsr data", ADDR_LSR, 32'h61);
    wr(ADDR_FCR, 32'hC7);
    rd_chk("lsr cleared", ADDR_LSR, 32'h60);
    end_sim();
  end
endmodule
